// ===== shared/ebm_pkg.sv
`default_nettype none
package ebm_pkg;
    localparam int INT_ADDR_W   = 24;
    localparam int PIN_ADDR_W   = 20;
    localparam int DATA_W       = 16;
    localparam int BYTE_W       = 8;
    localparam logic [23:0] RESET_FETCH_ADDR = 24'hff2080;

    // Phase lengths in clock cycles
    localparam logic [3:0] ADDR_PHASE_CYC = 4'h1;
    localparam logic [3:0] DATA_PHASE_CYC = 4'h2;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_ADDR   = 4'b0010,
        ST_DATA   = 4'b0100,
        ST_RESULT = 4'b1000
    } ebm_state_e;

    typedef enum logic [1:0] {
        BYTES_WORD = 2'h0,
        BYTES_LOW  = 2'h1,
        BYTES_HIGH = 2'h2
    } ebm_bytes_e;

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic        write;
        logic        external;
        logic        bus16;
        logic        muxed;
        ebm_bytes_e  bytes;
    } ebm_req_s;

    typedef struct packed {
        logic [15:0] rdata;
        logic        external;
    } ebm_rsp_s;
endpackage
`default_nettype wire

// ===== src/ebm_bus_mux.sv
`default_nettype none
module ebm_bus_mux
    import ebm_pkg::*;
(
    // Clock and reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  sys_rst_i,
    // Request from internal bus
    input  wire logic                  req_valid_i,
    output logic                       req_ready_o,
    input  wire ebm_req_s              req_i,
    input  wire logic [BYTE_W-1:0]     int_high_byte_i,
    // Response to internal bus
    output logic                       rsp_valid_o,
    input  wire logic                  rsp_ready_i,
    output ebm_rsp_s                   rsp_o,
    // Reset fetch address
    output logic [INT_ADDR_W-1:0]      reset_fetch_addr_o,
    // External pins
    output logic [DATA_W-1:0]          low_addr_lines_o,
    output logic [3:0]                 high_addr_lines_o,
    input  wire logic [DATA_W-1:0]     shared_addr_data_lines_i,
    output logic [DATA_W-1:0]          shared_addr_data_lines_o,
    output logic [DATA_W-1:0]          shared_addr_data_lines_oe_n_o,
    output logic                       addr_latch_o,
    output logic                       upper_byte_enable_n_o,
    output logic                       addr_bit_zero_o
);

    ebm_state_e              state_reg, state_next;
    ebm_req_s                cur_reg, cur_next;
    logic [3:0]              cnt_reg, cnt_next;
    logic [DATA_W-1:0]       low_reg, low_next;
    logic [3:0]              high_reg, high_next;
    logic [DATA_W-1:0]       ad_reg, ad_next;
    logic [DATA_W-1:0]       oe_reg, oe_next;
    logic                    ale_reg, ale_next;
    logic                    bhe_reg, bhe_next;
    logic [DATA_W-1:0]       rd_reg, rd_next;
    logic                    rdy_reg, rdy_next;
    logic                    rspv_reg, rspv_next;
    logic [INT_ADDR_W-1:0]   fetch_reg, fetch_next;
    // Two-entry result buffer
    // Ready waits for an empty buffer: simple ordering, less throughput
    ebm_rsp_s                buf_reg [2];
    ebm_rsp_s                buf_next [2];
    logic [1:0]              cnt_buf_reg, cnt_buf_next;

    localparam logic [DATA_W-1:0] ALL_DRIVE = 16'h0000;
    localparam logic [DATA_W-1:0] ALL_FLOAT = 16'hffff;
    localparam logic [DATA_W-1:0] HIGH_DRV  = 16'h00ff;

    // Data-phase drive pattern per mode
    function automatic logic [DATA_W-1:0] data_oe(input ebm_req_s r);
        if (r.write) begin
            data_oe = ALL_DRIVE;
        end else if (!r.bus16 && !r.muxed) begin
            data_oe = HIGH_DRV;
        end else if (!r.bus16) begin
            data_oe = HIGH_DRV;
        end else begin
            data_oe = ALL_FLOAT;
        end
    endfunction

    function automatic logic [DATA_W-1:0] data_val(input ebm_req_s r,
                                                    input logic [BYTE_W-1:0] hb);
        if (!r.bus16 && r.muxed) begin
            data_val = {r.addr[15:8], r.wdata[7:0]};
        end else if (!r.bus16) begin
            data_val = {hb, r.wdata[7:0]};
        end else begin
            data_val = r.wdata;
        end
    endfunction

    always_comb begin
        state_next   = state_reg;
        cur_next     = cur_reg;
        cnt_next     = cnt_reg;
        low_next     = low_reg;
        high_next    = high_reg;
        ad_next      = ad_reg;
        oe_next      = oe_reg;
        ale_next     = 1'b0;
        bhe_next     = bhe_reg;
        rd_next      = rd_reg;
        rdy_next     = 1'b0;
        buf_next     = buf_reg;
        cnt_buf_next = cnt_buf_reg;
        case (state_reg)
            ST_IDLE: begin
                rdy_next = (cnt_buf_reg == 2'h0);
                if (req_valid_i && rdy_reg) begin
                    cur_next = req_i;
                    if (req_i.external) begin
                        low_next  = req_i.addr[15:0];
                        high_next = req_i.addr[19:16];
                        bhe_next  = (req_i.bytes == BYTES_LOW) || !req_i.bus16;
                        ale_next  = 1'b1;
                        cnt_next  = ADDR_PHASE_CYC;
                        if (req_i.muxed) begin
                            ad_next = req_i.addr[15:0];
                            oe_next = ALL_DRIVE;
                        end else begin
                            ad_next = data_val(req_i, int_high_byte_i);
                            oe_next = data_oe(req_i);
                        end
                        state_next = ST_ADDR;
                    end else begin
                        rd_next    = {DATA_W{1'b0}};
                        state_next = ST_RESULT;
                    end
                    rdy_next = 1'b0;
                end
            end
            ST_ADDR: begin
                // Strobe drops after address phase, well before cycle end
                // Counts down, so a longer address phase needs only the constant
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h1) begin
                    ad_next    = data_val(cur_reg, int_high_byte_i);
                    oe_next    = data_oe(cur_reg);
                    cnt_next   = DATA_PHASE_CYC;
                    state_next = ST_DATA;
                end
            end
            ST_DATA: begin
                if (!cur_reg.bus16 && !cur_reg.muxed) begin
                    ad_next[15:8] = int_high_byte_i;
                end
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h1) begin
                    rd_next    = shared_addr_data_lines_i;
                    state_next = ST_RESULT;
                end
            end
            ST_RESULT: begin
                // Release the shared lines before the next cycle can start
                oe_next = ALL_FLOAT;
                buf_next[cnt_buf_reg[0]] = '{rdata: rd_reg, external: cur_reg.external};
                cnt_buf_next = cnt_buf_reg + 2'h1;
                state_next   = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
        // Drain side; receiver may stall without loss
        if (cnt_buf_reg != 2'h0 && rsp_ready_i && state_reg != ST_RESULT) begin
            buf_next[0]  = buf_reg[1];
            cnt_buf_next = cnt_buf_reg - 2'h1;
        end
        // Valid flop tracks the count in the same cycle
        rspv_next  = (cnt_buf_next != 2'h0);
        fetch_next = RESET_FETCH_ADDR;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_reg   <= ST_IDLE;
            cur_reg     <= '0;
            cnt_reg     <= 4'h0;
            low_reg     <= RESET_FETCH_ADDR[15:0];
            high_reg    <= RESET_FETCH_ADDR[19:16];
            ad_reg      <= '0;
            oe_reg      <= ALL_FLOAT;
            ale_reg     <= 1'b0;
            bhe_reg     <= 1'b1;
            rd_reg      <= '0;
            rdy_reg     <= 1'b0;
            buf_reg[0]  <= '0;
            buf_reg[1]  <= '0;
            cnt_buf_reg <= 2'h0;
            rspv_reg    <= 1'b0;
            fetch_reg   <= RESET_FETCH_ADDR;
        end else begin
            state_reg   <= state_next;
            cur_reg     <= cur_next;
            cnt_reg     <= cnt_next;
            low_reg     <= low_next;
            high_reg    <= high_next;
            ad_reg      <= ad_next;
            oe_reg      <= oe_next;
            ale_reg     <= ale_next;
            bhe_reg     <= bhe_next;
            rd_reg      <= rd_next;
            rdy_reg     <= rdy_next;
            buf_reg     <= buf_next;
            cnt_buf_reg <= cnt_buf_next;
            rspv_reg    <= rspv_next;
            fetch_reg   <= fetch_next;
        end
    end

    assign req_ready_o                   = rdy_reg;
    assign rsp_valid_o                   = rspv_reg;
    assign rsp_o                         = buf_reg[0];
    // Constant, kept in a flop so every pin output is registered
    assign reset_fetch_addr_o            = fetch_reg;
    assign low_addr_lines_o              = low_reg;
    assign high_addr_lines_o             = high_reg;
    assign shared_addr_data_lines_o      = ad_reg;
    assign shared_addr_data_lines_oe_n_o = oe_reg;
    assign addr_latch_o                  = ale_reg;
    assign upper_byte_enable_n_o         = bhe_reg;
    assign addr_bit_zero_o               = low_reg[0];

endmodule
`default_nettype wire

// ===== tb/ebm_bus_mux_asserts.sv
`default_nettype none
module ebm_bus_mux_asserts
    import ebm_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk_i,
    input wire logic        sys_rst_i,
    // Handshake
    input wire logic        req_valid_i,
    input wire logic        req_ready_o,
    input wire logic        rsp_valid_o,
    input wire ebm_req_s    req_i,
    // Pins
    input wire logic        addr_latch_o,
    input wire logic        upper_byte_enable_n_o,
    input wire logic        addr_bit_zero_o,
    input wire logic [23:0] reset_fetch_addr_o,
    input wire logic [15:0] low_addr_lines_o,
    input wire logic [15:0] shared_addr_data_lines_o,
    input wire logic [15:0] shared_addr_data_lines_oe_n_o,
    input wire logic [3:0]  high_addr_lines_o
);
    timeunit 1ns;
    timeprecision 100ps;
    ebm_req_s cur;
    wire logic tk = req_valid_i && req_ready_o;
    // Request copy; the port may change once taken
    always_ff @(posedge sys_clk_i) if (tk) cur <= req_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_take_ext; tk && req_i.external; endsequence
    sequence s_pulse; addr_latch_o ##1 !addr_latch_o; endsequence
    a_strobe_pulse: assert property (s_take_ext |=> s_pulse)
        else $error("strobe pulse wrong");
    a_strobe_only_ext: assert property (addr_latch_o |-> $past(tk && req_i.external))
        else $error("strobe without external take");
    a_addr_valid: assert property (addr_latch_o |->
        {high_addr_lines_o, low_addr_lines_o} == cur.addr[19:0]) else $error("address wrong");
    a_addr_hold: assert property (addr_latch_o |=>
        $stable({high_addr_lines_o, low_addr_lines_o})[*4]) else $error("address moved");
    a_mux_addr: assert property (addr_latch_o && cur.muxed |->
        shared_addr_data_lines_o == cur.addr[15:0] && shared_addr_data_lines_oe_n_o == 16'h0)
        else $error("muxed address wrong");
    a_mux8_upper: assert property (addr_latch_o && cur.muxed && !cur.bus16 |=>
        (shared_addr_data_lines_o[15:8] == cur.addr[15:8])[*3]) else $error("upper byte lost");
    a_demux_data: assert property (addr_latch_o && !cur.muxed && cur.bus16 && cur.write |->
        (shared_addr_data_lines_o == cur.wdata)[*3]) else $error("demux data wrong");
    a_byte_code: assert property (addr_latch_o |->
        upper_byte_enable_n_o == (!cur.bus16 || cur.bytes == BYTES_LOW) &&
        addr_bit_zero_o == cur.addr[0]) else $error("byte code wrong");
    a_int_quiet: assert property (tk && !req_i.external |=> !addr_latch_o ##1 rsp_valid_o)
        else $error("internal access wrong");
    a_fetch_addr: assert property (reset_fetch_addr_o == 24'hff2080)
        else $error("fetch address wrong");
endmodule
`default_nettype wire

// ===== tb/ebm_mem_model.sv
`default_nettype none
module ebm_mem_model (
    input  wire logic        clk_i,
    input  wire logic        latch_i,
    input  wire logic [15:0] addr_i, dout_i, oe_n_i,
    output logic      [15:0] din_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] held;
    logic [2:0]  cnt = 3'h0;
    logic        tog = 1'b0;
    always_ff @(posedge clk_i) begin
        tog <= !tog;
        if (latch_i) held <= addr_i;
        cnt <= latch_i ? 3'h5 : (cnt != 3'h0 ? cnt - 3'h1 : 3'h0);
    end
    // Outside its answer window the memory shows a toggling pattern, not stale data
    assign din_o = (~oe_n_i & dout_i) |
        (oe_n_i & (cnt != 3'h0 ? held ^ 16'h5a3c : {16{tog}}));
endmodule
`default_nettype wire

// ===== tb/ebm_bus_mux_tb.sv
`default_nettype none
module ebm_bus_mux_tb import ebm_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, rv = 0, rr = 0;
    logic [7:0] hb = 8'ha5;
    ebm_req_s rq = '0;
    ebm_rsp_s rsp;
    wire logic rdy, rspv, stb, bhe_n, a0;
    wire logic [23:0] rfa;
    wire logic [15:0] la, ado, oe_n, adi;
    wire logic [3:0] ha;
    int err_total = 0, num_checks = 0, cyc = 0;
    always #5 clk = !clk;
    ebm_bus_mux uut (.sys_clk_i(clk), .sys_rst_i(rst), .req_valid_i(rv), .req_ready_o(rdy),
        .req_i(rq), .int_high_byte_i(hb), .rsp_valid_o(rspv), .rsp_ready_i(rr), .rsp_o(rsp),
        .reset_fetch_addr_o(rfa), .low_addr_lines_o(la), .high_addr_lines_o(ha),
        .shared_addr_data_lines_i(adi), .shared_addr_data_lines_o(ado),
        .shared_addr_data_lines_oe_n_o(oe_n), .addr_latch_o(stb),
        .upper_byte_enable_n_o(bhe_n), .addr_bit_zero_o(a0));
    ebm_mem_model mem (.clk_i(clk), .latch_i(stb), .addr_i(la), .dout_i(ado), .oe_n_i(oe_n),
        .din_o(adi));
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        if (err_total == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) if (++cyc == 3000) begin
        err_total++;
        stop_test;
    end
    // One whole transfer; the result is held back for stall cycles
    task automatic run(input ebm_req_s r, input int stall, output logic [15:0] dat,
                       output logic [15:0] wbus, output int lat);
        int n;
        logic [15:0] oe_exp;
        n = 0;
        lat = 0;
        // Data phase: writes drive all, 8-bit reads keep the upper byte
        oe_exp = r.write ? 16'h0000 : (r.bus16 ? 16'hffff : 16'h00ff);
        @(posedge clk) #1 rv = 1;
        rq = r;
        do begin @(posedge clk); n++; end while (!rdy && n < 20);
        #1 rv = 0;
        do begin
            @(posedge clk);
            lat++;
            if (lat == 1) chk(stb, r.external);
            if (lat == 2) chk(stb, 1'b0);
            if (lat == 3) wbus = ado;
            if (lat == 3) chk(oe_n, oe_exp);
        end while (!rspv && lat < 20);
        dat = rsp.rdata;
        chk(rsp.external, r.external);
        repeat (stall) @(posedge clk);
        chk(rsp.rdata, dat);
        chk(rdy, 1'b0);
        #1 rr = 1;
        @(posedge clk) #1 rr = 0;
    endtask
    function automatic logic [15:0] exp_bus(ebm_req_s r, logic [15:0] src);
        return {r.bus16 ? src[15:8] : (r.muxed ? r.addr[15:8] : hb), src[7:0]};
    endfunction
    task automatic t_modes;
        ebm_req_s r;
        logic [15:0] d, w;
        int l;
        for (int i = 0; i < 8; i++) begin
            r = '{24'h9c4d6e, 16'h1234 + 16'(i), !i[2], 1'b1, i[1], i[0], BYTES_WORD};
            run(r, 0, d, w, l);
            chk(l, 5);
            chk({ha, la}, r.addr[19:0]);
            chk(bhe_n, !r.bus16);
            if (r.write) chk(w, exp_bus(r, r.wdata));
            else chk(d, exp_bus(r, r.addr[15:0] ^ 16'h5a3c));
        end
    endtask
    task automatic t_bytes;
        ebm_req_s r;
        logic [15:0] d, w;
        int l;
        for (int i = 0; i < 3; i++) begin
            r = '{24'h012340 | 24'(i), 16'h0, 1'b0, 1'b1, 1'b1, 1'b0, i ? BYTES_HIGH : BYTES_LOW};
            if (i == 2) r.bytes = BYTES_WORD;
            run(r, 0, d, w, l);
            chk({bhe_n, a0}, i == 2 ? 2'b00 : (i ? 2'b01 : 2'b10));
        end
    endtask
    task automatic t_internal;
        ebm_req_s r;
        logic [15:0] d, w;
        logic [19:0] pins;
        int l;
        pins = {ha, la};
        r = '{24'h001000, 16'h0, 1'b0, 1'b0, 1'b1, 1'b1, BYTES_WORD};
        run(r, 3, d, w, l);
        chk(l, 2);
        chk(d, 16'h0);
        chk({ha, la}, pins);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 rst = 0;
        @(posedge clk);
        chk({rfa, ha, la}, {24'hff2080, 20'hf2080});
        chk(oe_n, 16'hffff);
        t_modes();
        t_bytes();
        t_internal();
        stop_test();
    end
endmodule
bind ebm_bus_mux ebm_bus_mux_asserts u_chk (.*);
`default_nettype wire
